// ---- src/frp_consts.vh ----
// Purpose: constants for the flash region protection checker
// Assumes: 32 regions of 32 KiB over a 1 MiB flash offset space
// Notes: definitions only
`ifndef FRP_CONSTS_VH
`define FRP_CONSTS_VH
`define FRP_NUM_REGIONS 32
`define FRP_REGION_IDX_W 5
`define FRP_REGION_SHIFT 15
`define FRP_ADDR_W 32
`define FRP_DATA_W 32
`define FRP_NSC_ENTRIES 2
`define FRP_NSC_SIZE_W 4
`define FRP_NSC_UNIT_SHIFT 5
`define FRP_PERM_READ 0
`define FRP_PERM_WRITE 1
`define FRP_PERM_EXEC 2
`define FRP_PERM_SECURE 3
`define FRP_PERM_W 4
`define FRP_PERM_RESET 4'hF
`define FRP_FLASH_BASE 32'h00000000
`define FRP_FLASH_SIZE 32'h00100000
`define FRP_FACTORY_INFO_AREA_BASE 32'h00FF0000
`define FRP_FACTORY_INFO_AREA_SIZE 32'h00001000
`define FRP_UCFG_BASE 32'h00FF8000
`define FRP_UCFG_SIZE 32'h00001000
`define FRP_ACC_READ 2'h0
`define FRP_ACC_WRITE 2'h1
`define FRP_ACC_ERASE 2'h2
`define FRP_ACC_FETCH 2'h3
`endif

// ---- src/frp_perm_bank.v ----
// Purpose: per-region permission words with freeze bits
// Assumes: one write port, synchronous active-low reset
// Notes: frozen regions ignore writes until reset
`timescale 1ns/1ps
`include "frp_consts.vh"
module frp_perm_bank #(
	parameter NUM_REGIONS = `FRP_NUM_REGIONS,
	parameter IDX_W = `FRP_REGION_IDX_W
)(
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Configuration write port
	input wire cfg_we,
	input wire [IDX_W-1:0] cfg_idx,
	input wire [`FRP_PERM_W-1:0] cfg_perm,
	input wire cfg_freeze,
	// Flattened permission words and freeze states
	output wire [NUM_REGIONS*`FRP_PERM_W-1:0] perm_flat,
	output wire [NUM_REGIONS-1:0] frozen
);
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGIONS; gi = gi + 1)
		begin : g_reg
			reg [`FRP_PERM_W-1:0] perm_q;
			reg frz_q;
			wire hit;
			// A genvar cannot be part-selected, so its index is held at the port width
			localparam [IDX_W-1:0] MY_IDX = gi;
			assign hit = cfg_we && (cfg_idx == MY_IDX) && !frz_q;
			// Freeze bit also blocks its own clearing
			always @(posedge clk_sys)
			begin
				if (!rst_n)
				begin
					perm_q <= `FRP_PERM_RESET;
					frz_q <= 1'b0;
				end
				else if (hit)
				begin
					perm_q <= cfg_perm;
					frz_q <= cfg_freeze;
				end
			end
			assign perm_flat[gi*`FRP_PERM_W +: `FRP_PERM_W] = perm_q;
			assign frozen[gi] = frz_q;
		end
	endgenerate
endmodule // frp_perm_bank

// ---- src/frp_nsc_map.v ----
// Purpose: resolve callable sub-region entries into per-region sizes
// Assumes: entry sizes are power-of-two-free units of 32 bytes
// Notes: purely combinational
`timescale 1ns/1ps
`include "frp_consts.vh"
module frp_nsc_map #(
	parameter NUM_REGIONS = `FRP_NUM_REGIONS,
	parameter IDX_W = `FRP_REGION_IDX_W,
	parameter ENTRIES = `FRP_NSC_ENTRIES,
	parameter SIZE_W = `FRP_NSC_SIZE_W
)(
	// Entry configuration
	input wire [ENTRIES*IDX_W-1:0] nsc_region_flat,
	input wire [ENTRIES*SIZE_W-1:0] nsc_size_flat,
	// Secure bits per region
	input wire [NUM_REGIONS-1:0] region_secure,
	// Effective size per region, zero where no sub-region exists
	output reg [NUM_REGIONS*SIZE_W-1:0] eff_size_flat
);
	integer r;
	integer e;
	reg [SIZE_W-1:0] sz;
	reg [IDX_W-1:0] rsel;
	// Largest nonzero size among entries naming a secure region
	always @*
	begin
		eff_size_flat = {NUM_REGIONS*SIZE_W{1'b0}};
		for (r = 0; r < NUM_REGIONS; r = r + 1)
		begin
			for (e = 0; e < ENTRIES; e = e + 1)
			begin
				rsel = nsc_region_flat[e*IDX_W +: IDX_W];
				sz = nsc_size_flat[e*SIZE_W +: SIZE_W];
				if ((rsel == r[IDX_W-1:0]) && region_secure[r] && (sz != {SIZE_W{1'b0}}))
				begin
					if (sz > eff_size_flat[r*SIZE_W +: SIZE_W])
						eff_size_flat[r*SIZE_W +: SIZE_W] = sz;
				end
			end
		end
	end
endmodule // frp_nsc_map

// ---- src/frp_checker.v ----
// Purpose: flash region access checker controlled by the protection unit
// Assumes: one transfer per cycle, address phase and data phase in the same cycle
// Notes: verdict is combinational; event and error outputs are registered
`timescale 1ns/1ps
`include "frp_consts.vh"
module frp_checker #(
	parameter NUM_REGIONS = `FRP_NUM_REGIONS,
	parameter IDX_W = `FRP_REGION_IDX_W,
	parameter ENTRIES = `FRP_NSC_ENTRIES,
	parameter SIZE_W = `FRP_NSC_SIZE_W,
	parameter NUM_MASTERS = 4
)(
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Permission configuration
	input wire cfg_perm_we,
	input wire [IDX_W-1:0] cfg_perm_idx,
	input wire [`FRP_PERM_W-1:0] cfg_perm_val,
	input wire cfg_perm_freeze,
	output wire [NUM_REGIONS-1:0] region_frozen,
	// Callable sub-region entries
	input wire [ENTRIES*IDX_W-1:0] nsc_region_flat,
	input wire [ENTRIES*SIZE_W-1:0] nsc_size_flat,
	// Per-master security attribute for non-core masters
	input wire [NUM_MASTERS-1:0] master_secure_attr,
	// Interrupt enable for the access-error event
	input wire access_err_irq_en,
	// Debug session active
	input wire debug_active,
	// Incoming transfer from a master
	input wire req_valid,
	input wire [`FRP_ADDR_W-1:0] req_addr,
	input wire [1:0] req_kind,
	input wire req_is_core,
	input wire req_core_secure,
	input wire [1:0] req_master_id,
	input wire req_err_capable,
	input wire [`FRP_DATA_W-1:0] req_wdata,
	// Transfer forwarded to the flash
	output wire fwd_valid,
	output wire [`FRP_ADDR_W-1:0] fwd_addr,
	output wire [1:0] fwd_kind,
	output wire [`FRP_DATA_W-1:0] fwd_wdata,
	// Read data from flash and toward the master
	input wire [`FRP_DATA_W-1:0] flash_rdata,
	output wire [`FRP_DATA_W-1:0] rsp_rdata,
	// Verdict and reporting
	output wire access_blocked,
	output wire in_nsc_subregion,
	output reg bus_error_q,
	output reg security_fault_q,
	output reg bus_fault_q,
	output reg access_error_event_q,
	output reg access_error_irq_q
);
	wire [NUM_REGIONS*`FRP_PERM_W-1:0] perm_flat;
	wire [NUM_REGIONS*SIZE_W-1:0] eff_size_flat;
	wire [NUM_REGIONS-1:0] region_secure;
	wire [IDX_W-1:0] region_idx;
	wire [`FRP_PERM_W-1:0] perm;
	wire [SIZE_W-1:0] nsc_size;
	wire [`FRP_REGION_SHIFT-1:0] region_off;
	wire [`FRP_REGION_SHIFT:0] nsc_bytes;
	wire [`FRP_ADDR_W-1:0] flash_off;
	wire in_flash;
	wire in_factory_info_area;
	wire in_ucfg;
	wire xfer_secure;
	wire is_read;
	wire is_write;
	wire is_fetch;
	wire sec_viol;
	wire perm_viol;
	wire any_viol;
	genvar gi;

	// Permission storage with freeze
	frp_perm_bank #(
		.NUM_REGIONS(NUM_REGIONS),
		.IDX_W(IDX_W)
	) u_bank (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cfg_we(cfg_perm_we),
		.cfg_idx(cfg_perm_idx),
		.cfg_perm(cfg_perm_val),
		.cfg_freeze(cfg_perm_freeze),
		.perm_flat(perm_flat),
		.frozen(region_frozen)
	);

	// Secure bit of each region feeds the sub-region resolver
	generate
		for (gi = 0; gi < NUM_REGIONS; gi = gi + 1)
		begin : g_sec
			assign region_secure[gi] = perm_flat[gi*`FRP_PERM_W + `FRP_PERM_SECURE];
		end
	endgenerate

	frp_nsc_map #(
		.NUM_REGIONS(NUM_REGIONS),
		.IDX_W(IDX_W),
		.ENTRIES(ENTRIES),
		.SIZE_W(SIZE_W)
	) u_nsc (
		.nsc_region_flat(nsc_region_flat),
		.nsc_size_flat(nsc_size_flat),
		.region_secure(region_secure),
		.eff_size_flat(eff_size_flat)
	);

	// Address decode; region index from bits above the 32 KiB boundary
	assign flash_off = req_addr - `FRP_FLASH_BASE;
	assign in_flash = (req_addr >= `FRP_FLASH_BASE) && (flash_off < `FRP_FLASH_SIZE);
	assign in_factory_info_area = (req_addr >= `FRP_FACTORY_INFO_AREA_BASE) && (req_addr < (`FRP_FACTORY_INFO_AREA_BASE + `FRP_FACTORY_INFO_AREA_SIZE));
	assign in_ucfg = (req_addr >= `FRP_UCFG_BASE) && (req_addr < (`FRP_UCFG_BASE + `FRP_UCFG_SIZE));
	assign region_idx = flash_off[`FRP_REGION_SHIFT +: IDX_W];
	assign region_off = flash_off[`FRP_REGION_SHIFT-1:0];
	assign perm = perm_flat[region_idx*`FRP_PERM_W +: `FRP_PERM_W];

	// Sub-region occupies the top nsc_bytes of the region
	assign nsc_size = eff_size_flat[region_idx*SIZE_W +: SIZE_W];
	assign nsc_bytes = {{(`FRP_REGION_SHIFT+1-SIZE_W){1'b0}}, nsc_size} << `FRP_NSC_UNIT_SHIFT;
	assign in_nsc_subregion = in_flash && (nsc_size != {SIZE_W{1'b0}})
		&& ({1'b0, region_off} >= ((17'h08000) - nsc_bytes));

	// Transfer security: core by its state, others by the setting
	assign xfer_secure = req_is_core ? req_core_secure : master_secure_attr[req_master_id];

	assign is_read = (req_kind == `FRP_ACC_READ);
	assign is_write = (req_kind == `FRP_ACC_WRITE) || (req_kind == `FRP_ACC_ERASE);
	assign is_fetch = (req_kind == `FRP_ACC_FETCH);

	// Security check; factory and user areas always secure
	assign sec_viol = req_valid && !xfer_secure
		&& ((in_flash && perm[`FRP_PERM_SECURE]) || in_factory_info_area || in_ucfg);

	// Permission check; debug may fetch from protected code
	assign perm_viol = req_valid && (
		(in_flash && is_read && !perm[`FRP_PERM_READ]) ||
		(in_flash && is_write && !perm[`FRP_PERM_WRITE]) ||
		(in_flash && is_fetch && !perm[`FRP_PERM_EXEC] && !debug_active) ||
		(in_factory_info_area && is_write) ||
		((in_factory_info_area || in_ucfg) && is_fetch && !debug_active));

	assign any_viol = sec_viol || perm_viol;
	assign access_blocked = any_viol;

	// Blocked transfers never reach the flash
	assign fwd_valid = req_valid && !any_viol;
	assign fwd_addr = req_addr;
	assign fwd_kind = req_kind;
	assign fwd_wdata = req_wdata;
	assign rsp_rdata = any_viol ? {`FRP_DATA_W{1'b0}} : flash_rdata;

	// Reporting registered one cycle after the offending transfer
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			bus_error_q <= 1'b0;
			security_fault_q <= 1'b0;
			bus_fault_q <= 1'b0;
			access_error_event_q <= 1'b0;
			access_error_irq_q <= 1'b0;
		end
		else
		begin
			bus_error_q <= any_viol && req_err_capable;
			security_fault_q <= req_is_core && sec_viol;
			bus_fault_q <= req_is_core && perm_viol && !sec_viol;
			// Core security violations stay off the event line
			access_error_event_q <= req_is_core ? (perm_viol && !sec_viol) : any_viol;
			access_error_irq_q <= access_err_irq_en
				&& (req_is_core ? (perm_viol && !sec_viol) : any_viol);
		end
	end
endmodule // frp_checker

// ---- tb/frp_props.sv ----
// Purpose: port-level assertions for the flash region checker
// Assumes: one clock, synchronous active-low reset
// Notes: fault and event pulses follow the violating edge by one cycle
`timescale 1ns/1ps
`include "frp_consts.vh"
module frp_props (
	// Clock, reset and request qualifiers
	input wire clk_sys,
	input wire rst_n,
	input wire req_valid,
	input wire req_is_core,
	input wire req_err_capable,
	input wire access_err_irq_en,
	// Verdict and reporting outputs
	input wire access_blocked,
	input wire fwd_valid,
	input wire [`FRP_DATA_W-1:0] rsp_rdata,
	input wire bus_error_q,
	input wire security_fault_q,
	input wire bus_fault_q,
	input wire access_error_event_q,
	input wire access_error_irq_q
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// A refused transfer in flight
	wire blk = req_valid && access_blocked;
	chk_blk_zero: assert property (access_blocked |-> rsp_rdata == 0)
		else $error("read data leaks on a block");
	chk_blk_nofwd: assert property (blk |-> !fwd_valid)
		else $error("blocked transfer forwarded");
	chk_pass_fwd: assert property (req_valid && !access_blocked |-> fwd_valid)
		else $error("allowed transfer not forwarded");
	chk_sf_alone: assert property (security_fault_q |-> !bus_fault_q && !access_error_event_q)
		else $error("security fault not alone");
	chk_bf_event: assert property (bus_fault_q |-> access_error_event_q)
		else $error("bus fault without event");
	chk_dma_event: assert property (blk && !req_is_core |=> access_error_event_q && !security_fault_q)
		else $error("non-core violation misreported");
	chk_core_fault: assert property (blk && req_is_core |=> security_fault_q != bus_fault_q)
		else $error("core violation needs one fault");
	chk_err_resp: assert property (blk && req_err_capable |=> bus_error_q)
		else $error("bus error missing");
	chk_pulse_cause: assert property (bus_error_q || access_error_event_q |-> $past(blk))
		else $error("pulse without violation");
	chk_irq_gate: assert property (access_error_irq_q |-> access_error_event_q && $past(access_err_irq_en))
		else $error("interrupt not gated");
	cover property (blk && req_is_core);
	cover property (blk && !req_is_core);
	cover property (access_error_irq_q);
endmodule // frp_props
bind frp_checker frp_props u_props (.*);

// ---- tb/frp_flash_model.sv ----
// Purpose: behavioural flash array behind the checker
// Assumes: read data answered in the cycle of the forwarded transfer
// Notes: idle data flips every cycle so stale values never pass
`timescale 1ns/1ps
module frp_flash_model (
	// Clock and forwarded transfer
	input wire clk_sys,
	input wire fwd_valid,
	input wire [31:0] fwd_addr,
	// Read data toward the checker
	output wire [31:0] flash_rdata
);
	reg [31:0] idle_q = 32'hA5A5A5A5;
	// Content is a fixed function of the address
	always @(posedge clk_sys) idle_q <= ~idle_q;
	assign flash_rdata = fwd_valid ? (fwd_addr ^ 32'hC3C3C3C3) : idle_q;
endmodule // frp_flash_model

// ---- tb/flash_region_protection_tb.sv ----
// Purpose: self-checking bench for the flash region checker
// Assumes: inputs change 1 ns after the rising edge
// Notes: mirror of permissions predicts verdicts and pulses
`timescale 1ns/1ps
`include "frp_consts.vh"
module flash_region_protection_tb;
	reg clk_sys = 0, rst_n = 0, cfg_perm_we = 0, cfg_perm_freeze = 0, access_err_irq_en = 0, debug_active = 0;
	reg req_valid = 0, req_is_core = 0, req_core_secure = 0, req_err_capable = 0;
	reg [4:0] cfg_perm_idx = 0;
	reg [3:0] cfg_perm_val = 0, master_secure_attr = 4'h5;
	reg [9:0] nsc_region_flat = 0;
	reg [7:0] nsc_size_flat = 0;
	reg [31:0] req_addr = 0, req_wdata = 0, r, a, frz_m;
	reg [1:0] req_kind = 0, req_master_id = 0;
	reg [3:0] perm_m [0:31];
	reg [4:0] exp_q;
	wire [31:0] fwd_addr, fwd_wdata, flash_rdata, rsp_rdata, region_frozen;
	wire [1:0] fwd_kind;
	wire fwd_valid, access_blocked, in_nsc_subregion, bus_error_q, security_fault_q, bus_fault_q;
	wire access_error_event_q, access_error_irq_q;
	integer err_count = 0, check_count = 0, seed = 5, i;
	frp_checker dut (.*);
	frp_flash_model u_flash (.*);
	initial forever #2 clk_sys = ~clk_sys;
	// Watchdog: the run needs under two microseconds
	initial begin #20000; err_count = err_count + 1; wrap_up; end
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
		check_count = check_count + 1;
		if (seen !== exp) begin err_count = err_count + 1; $display("[FAIL] %s expected %h seen %h", nm, exp, seen); end
		end
	endtask
	task wrap_up;
		begin
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
		end
	endtask
	// Permission write; the mirror ignores frozen regions
	task cfg(input [4:0] idx, input [3:0] v, input f);
		begin
		cfg_perm_idx = idx; cfg_perm_val = v; cfg_perm_freeze = f; cfg_perm_we = 1;
		if (!frz_m[idx]) begin perm_m[idx] = v; frz_m[idx] = f; end
		@(posedge clk_sys); #1 cfg_perm_we = 0;
		end
	endtask
	// One cycle of traffic; also checks the pulses of the previous cycle
	task xfer(input v, input [31:0] ad, input [1:0] k, input c, input cs, input [1:0] id, input e, input d);
		reg [3:0] p;
		reg sec, sv, pv, b, ev;
		integer u, j;
		begin
		req_valid = v; req_addr = ad; req_kind = k; req_is_core = c; req_core_secure = cs;
		req_master_id = id; req_err_capable = e; debug_active = d;
		req_wdata = $random(seed); access_err_irq_en = $random(seed);
		#1;
		chk("pulses", {access_error_irq_q, access_error_event_q, bus_fault_q, security_fault_q, bus_error_q}, exp_q);
		// Fixed areas: always secure, fetch only while debugging
		if (ad >= `FRP_UCFG_BASE) p = {1'b1, d, 2'b11};
		else if (ad >= `FRP_FACTORY_INFO_AREA_BASE) p = {1'b1, d, 2'b01};
		else p = perm_m[ad[19:15]];
		sec = c ? cs : master_secure_attr[id];
		sv = p[3] && !sec;
		pv = (k == 0) ? !p[0] : (k == 3) ? !(p[2] || d) : !p[1];
		b = v && (sv || pv);
		ev = b && !(c && sv);
		chk("blocked", access_blocked, b);
		chk("fwd_valid", fwd_valid, v && !b);
		if (v && !b) chk("fwd_addr", fwd_addr, ad);
		if (v && !b) chk("fwd_kind", fwd_kind, k);
		if (v && !b) chk("fwd_wdata", fwd_wdata, req_wdata);
		if (v) chk("rsp_rdata", rsp_rdata, b ? 32'h0 : ad ^ 32'hC3C3C3C3);
		u = 0;
		for (j = 0; j < 2; j = j + 1)
			if (nsc_region_flat[5*j+:5] == ad[19:15] && nsc_size_flat[4*j+:4] > u) u = nsc_size_flat[4*j+:4];
		if (v && ad < `FRP_FLASH_SIZE) chk("nsc", in_nsc_subregion, p[3] && u != 0 && ad[14:0] >= 32768 - 32 * u);
		exp_q = {ev && access_err_irq_en, ev, b && c && !sv, b && c && sv, b && e};
		@(posedge clk_sys); #1;
		end
	endtask
	initial begin
		frz_m = 0;
		exp_q = 0;
		for (i = 0; i < 32; i = i + 1) perm_m[i] = 4'hF;
		repeat (5) @(posedge clk_sys);
		#1 rst_n = 1;
		chk("frozen", region_frozen, 32'h0);
		// Reset leaves every region secure: a non-secure master is refused
		xfer(1, 32'h100, 0, 0, 0, 1, 1, 0);
		xfer(0, 0, 0, 0, 0, 0, 0, 0);
		for (i = 0; i < 32; i = i + 1) cfg(i, $random(seed), 0);
		// Freeze region 3 as read-only non-secure, then try to undo it
		cfg(3, 4'h1, 1);
		cfg(3, 4'hF, 0);
		chk("frozen", region_frozen, 32'h8);
		xfer(1, 32'h18000, 1, 1, 0, 0, 1, 0);
		// Two entries on secure region 5: the larger size sets the edge
		xfer(0, 0, 0, 0, 0, 0, 0, 0);
		cfg(5, 4'hF, 0);
		nsc_region_flat = {5'd5, 5'd5};
		nsc_size_flat = 8'h27;
		xfer(1, 32'h2FF1F, 0, 1, 1, 0, 0, 0);
		xfer(1, 32'h2FF20, 0, 1, 1, 0, 0, 0);
		// Fixed areas with every kind, then non-secure and debug cases
		for (i = 0; i < 8; i = i + 1) xfer(1, i[0] ? `FRP_UCFG_BASE : `FRP_FACTORY_INFO_AREA_BASE, i[2:1], 1, 1, 0, 1, 0);
		xfer(1, `FRP_UCFG_BASE + 4, 0, 1, 0, 0, 1, 0);
		xfer(1, `FRP_FACTORY_INFO_AREA_BASE + 8, 3, 1, 1, 0, 0, 1);
		// Random traffic, biased toward the tops of regions
		for (i = 0; i < 400; i = i + 1)
		begin
			r = $random(seed);
			a = $random(seed);
			nsc_region_flat = a[29:20];
			nsc_size_flat = r[31:24];
			a = (a & 32'hFFFFF) | (r[12] ? 32'h7E00 : 32'h0);
			xfer(r[0] | r[1], a, r[3:2], r[4], r[5], r[7:6], r[8], r[9]);
		end
		xfer(0, 0, 0, 0, 0, 0, 0, 0);
		wrap_up;
	end
endmodule // flash_region_protection_tb
